// *** dpc_port_ctrl.sv ***
/*
 * Host-side controller for one port of an asynchronous dual-port memory.
 * A user request (array or flag, read or write) becomes a pin sequence.
 * Assumes the memory pins are asynchronous; inputs from them pass two flops.
 */
`timescale 1ns/1ps
module dpc_port_ctrl (
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic                        req_valid,     // Request pulse, taken in idle.
    input  wire logic                        req_write,     // 1 = write, 0 = read.
    input  wire logic                        req_flag,      // 1 = semaphore flag access.
    input  wire logic [dpc_pkg::ADDR_W-1:0]  req_addr,      // Word or flag address.
    input  wire logic [dpc_pkg::DATA_W-1:0]  req_wdata,     // Write data.
    input  wire logic [1:0]                  req_lanes,     // Bit 1 upper lane, bit 0 lower lane.
    output logic                             req_ready,     // High while idle.
    output logic                             rsp_valid,     // One-cycle completion pulse.
    output logic [dpc_pkg::DATA_W-1:0]       rsp_rdata,     // Read data.
    output logic                             rsp_blocked,   // Write saw contention low.
    output logic [dpc_pkg::ADDR_W-1:0]       mem_addr,
    output logic                             port_select_n,
    output logic                             write_strobe_n,
    output logic                             output_enable_n,
    output logic                             upper_byte_select_n,
    output logic                             lower_byte_select_n,
    output logic                             flag_access_select_n,
    input  wire logic [dpc_pkg::DATA_W-1:0]  data_in,
    output logic [dpc_pkg::DATA_W-1:0]       data_out,
    output logic                             data_oe,       // High while the host drives data.
    input  wire logic                        contention_n,  // Contention pin seen from this port.
    input  wire logic                        mailbox_n      // Mailbox interrupt pin of this port.
    ,output logic                            mailbox_pending // Synchronised mailbox level.
);
    // Phase counter and state.
    dpc_pkg::dpc_state_t state_reg, state_next;
    logic [dpc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    // Latched request and response.
    logic wr_reg, wr_next, flag_reg, flag_next;
    logic [1:0] lanes_reg, lanes_next;
    logic [dpc_pkg::DATA_W-1:0] rdata_reg, rdata_next;
    logic blocked_reg, blocked_next, valid_reg, valid_next;
    // Pin registers.
    logic [dpc_pkg::ADDR_W-1:0] addr_reg, addr_next;
    logic [dpc_pkg::DATA_W-1:0] dout_reg, dout_next;
    logic cs_reg, cs_next, we_reg, we_next, oe_reg, oe_next;
    logic ub_reg, ub_next, lb_reg, lb_next, sem_reg, sem_next, doe_reg, doe_next;
    // Two-flop synchronisers for asynchronous pin inputs.
    logic [dpc_pkg::DATA_W-1:0] din_s1_reg, din_s2_reg;
    logic busy_s1_reg, busy_s2_reg, mb_s1_reg, mb_s2_reg;
    logic mb_pend_reg;              // Registered mailbox pending level, so the output comes from a flop.
    logic ready_reg, ready_next;    // Registered idle indication for the request side.

    // Synchronisers: the first stage feeds only the second.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            din_s1_reg  <= 16'h0000;
            din_s2_reg  <= 16'h0000;
            busy_s1_reg <= 1'b1;
            busy_s2_reg <= 1'b1;
            mb_s1_reg   <= 1'b1;
            mb_s2_reg   <= 1'b1;
            mb_pend_reg <= 1'b0;
        end else begin
            din_s1_reg  <= data_in;
            din_s2_reg  <= din_s1_reg;
            busy_s1_reg <= contention_n;
            busy_s2_reg <= busy_s1_reg;
            mb_s1_reg   <= mailbox_n;
            mb_s2_reg   <= mb_s1_reg;
            // A third stage only inverts, so the first stage still feeds the second alone.
            mb_pend_reg <= ~mb_s2_reg;
        end
    end

    // Sequencer next-state logic.
    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        wr_next      = wr_reg;
        flag_next    = flag_reg;
        lanes_next   = lanes_reg;
        rdata_next   = rdata_reg;
        blocked_next = blocked_reg;
        valid_next   = 1'b0;
        addr_next    = addr_reg;
        dout_next    = dout_reg;
        cs_next      = cs_reg;
        we_next      = we_reg;
        oe_next      = oe_reg;
        ub_next      = ub_reg;
        lb_next      = lb_reg;
        sem_next     = sem_reg;
        doe_next     = doe_reg;
        case (state_reg)
            dpc_pkg::DPC_IDLE: begin
                // All strobes high here, so address may move safely.
                if (req_valid) begin
                    wr_next      = req_write;
                    flag_next    = req_flag;
                    lanes_next   = req_flag ? 2'h3 : req_lanes;
                    blocked_next = 1'b0;
                    // Flags use the three low address bits only.
                    addr_next    = req_flag ? {{(dpc_pkg::ADDR_W-dpc_pkg::FLAG_IDX_W){1'b0}},
                                   req_addr[dpc_pkg::FLAG_IDX_W-1:0]} : req_addr;
                    // A flag write carries its value on bit zero only.
                    dout_next    = req_flag ? {15'h0000, req_wdata[dpc_pkg::FLAG_BIT]} : req_wdata;
                    state_next   = dpc_pkg::DPC_SETUP;
                end
            end
            dpc_pkg::DPC_SETUP: begin
                // Address is stable a full cycle before any strobe falls.
                // Port select stays high in flag cycles; never both low.
                cs_next  = flag_reg;
                sem_next = ~flag_reg;
                ub_next  = ~lanes_reg[1];
                lb_next  = ~lanes_reg[0];
                cnt_next = '0;
                if (wr_reg) begin
                    // Strobe falls with the selects so outputs stay off.
                    we_next    = 1'b0;
                    doe_next   = 1'b1;
                    state_next = dpc_pkg::DPC_WRITE;
                end else begin
                    // Data driver is off before output enable falls.
                    oe_next    = 1'b0;
                    state_next = dpc_pkg::DPC_READ;
                end
            end
            dpc_pkg::DPC_WRITE: begin
                // Contention low during a write means it was inhibited.
                if (!busy_s2_reg) begin
                    blocked_next = 1'b1;
                end
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == dpc_pkg::CNT_W'(dpc_pkg::WRITE_PULSE_CYC - 1)) begin
                    // Strobe rises first and ends the write; flag latches here.
                    we_next    = 1'b1;
                    state_next = dpc_pkg::DPC_DONE;
                end
            end
            dpc_pkg::DPC_READ: begin
                cnt_next = cnt_reg + 1'b1;
                // Extra two cycles cover the input synchroniser.
                if (cnt_reg == dpc_pkg::CNT_W'(dpc_pkg::READ_ACCESS_CYC + 1)) begin
                    rdata_next = din_s2_reg;
                    oe_next    = 1'b1;
                    state_next = dpc_pkg::DPC_DONE;
                end
            end
            dpc_pkg::DPC_DONE: begin
                // Release selects and the data driver together, before address moves.
                cs_next    = 1'b1;
                sem_next   = 1'b1;
                ub_next    = 1'b1;
                lb_next    = 1'b1;
                doe_next   = 1'b0;
                valid_next = 1'b1;
                state_next = dpc_pkg::DPC_IDLE;
            end
            default: begin
                state_next = dpc_pkg::DPC_IDLE;
            end
        endcase
        // Ready follows the state that the coming edge loads, so it can be a flop.
        ready_next = (state_next == dpc_pkg::DPC_IDLE);
    end

    // Register stage; all strobes inactive after reset.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg   <= dpc_pkg::DPC_IDLE;
            cnt_reg     <= '0;
            wr_reg      <= 1'b0;
            flag_reg    <= 1'b0;
            lanes_reg   <= 2'h0;
            rdata_reg   <= 16'h0000;
            blocked_reg <= 1'b0;
            valid_reg   <= 1'b0;
            addr_reg    <= 12'h000;
            dout_reg    <= 16'h0000;
            cs_reg      <= 1'b1;
            we_reg      <= 1'b1;
            oe_reg      <= 1'b1;
            ub_reg      <= 1'b1;
            lb_reg      <= 1'b1;
            sem_reg     <= 1'b1;
            doe_reg     <= 1'b0;
            ready_reg   <= 1'b1;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            wr_reg      <= wr_next;
            flag_reg    <= flag_next;
            lanes_reg   <= lanes_next;
            rdata_reg   <= rdata_next;
            blocked_reg <= blocked_next;
            valid_reg   <= valid_next;
            addr_reg    <= addr_next;
            dout_reg    <= dout_next;
            cs_reg      <= cs_next;
            we_reg      <= we_next;
            oe_reg      <= oe_next;
            ub_reg      <= ub_next;
            lb_reg      <= lb_next;
            sem_reg     <= sem_next;
            doe_reg     <= doe_next;
            ready_reg   <= ready_next;
        end
    end

    // Outputs come straight from flops.
    assign req_ready            = ready_reg;
    assign rsp_valid            = valid_reg;
    assign rsp_rdata            = rdata_reg;
    assign rsp_blocked          = blocked_reg;
    assign mem_addr             = addr_reg;
    assign port_select_n        = cs_reg;
    assign write_strobe_n       = we_reg;
    assign output_enable_n      = oe_reg;
    assign upper_byte_select_n  = ub_reg;
    assign lower_byte_select_n  = lb_reg;
    assign flag_access_select_n = sem_reg;
    assign data_out             = dout_reg;
    assign data_oe              = doe_reg;
    assign mailbox_pending      = mb_pend_reg;  // Software clears it by reading its mailbox word.

    // Address moves only while the write strobe is high.
    a_addr_stable_strobe: assert property (@(posedge ref_clk) disable iff (rst)
        !write_strobe_n |-> $stable(mem_addr))
        else $error("Address changed during write strobe.");
    // Never drive data with output enable low.
    a_no_bus_fight: assert property (@(posedge ref_clk) disable iff (rst)
        !(data_oe && !output_enable_n))
        else $error("Host drives data while memory outputs.");
    // Port select and flag select never both low.
    a_sel_exclusive: assert property (@(posedge ref_clk) disable iff (rst)
        !(!port_select_n && !flag_access_select_n))
        else $error("Port and flag selects both low.");
    // Write strobe low exactly the write pulse cycles.
    a_write_pulse_len: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(write_strobe_n) |-> !write_strobe_n [*2] ##1 write_strobe_n)
        else $error("Write pulse length wrong.");
    // Strobe falls together with the selects, never before them.
    a_strobe_with_sel: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(write_strobe_n) |-> (!port_select_n || !flag_access_select_n) && data_oe)
        else $error("Write strobe fell without a select.");
    // Flag write data has only bit zero.
    a_flag_bit_zero: assert property (@(posedge ref_clk) disable iff (rst)
        (!flag_access_select_n && data_oe) |-> (data_out[15:1] == 15'h0000))
        else $error("Flag write data uses upper bits.");
    // Flag address uses the three low bits only.
    a_flag_addr_low: assert property (@(posedge ref_clk) disable iff (rst)
        !flag_access_select_n |-> (mem_addr[11:3] == 9'h000))
        else $error("Flag address has high bits set.");
    // A request completes within a bounded time.
    a_req_done: assert property (@(posedge ref_clk) disable iff (rst)
        (req_valid && req_ready) |-> ##[3:8] rsp_valid)
        else $error("Request did not complete in time.");
    c_array_write: cover property (@(posedge ref_clk) disable iff (rst)
        $fell(write_strobe_n) && !port_select_n);
    c_flag_read: cover property (@(posedge ref_clk) disable iff (rst)
        $fell(output_enable_n) && !flag_access_select_n);
    c_blocked: cover property (@(posedge ref_clk) disable iff (rst) rsp_valid && rsp_blocked);
endmodule

// *** dpc_pkg.sv ***
/*
 * Constants shared by the dual-port memory port controller: pin widths,
 * special addresses, field positions and the access sequencer's timing counts.
 * Assumes a 25 MHz ref_clk; the controller drives one port of the memory.
 */
package dpc_pkg;
    localparam int ADDR_W = 12;                      // Address width of one port.
    localparam int DATA_W = 16;                      // Data width of one port.
    localparam int CLK_PERIOD_NS = 40;               // ref_clk period.
    localparam int WRITE_PULSE_NS = 50;              // Least write strobe low time.
    localparam int READ_ACCESS_NS = 70;              // Longest read access time.
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 3;                        // Width of the phase counter.
    localparam logic [ADDR_W-1:0] MAILBOX_RIGHT_ADDR = 12'hFFF; // Mailbox of the right port.
    localparam logic [ADDR_W-1:0] MAILBOX_LEFT_ADDR = 12'hFFE;  // Mailbox of the left port.
    localparam int FLAG_IDX_W = 3;                   // Flag index field width.
    localparam int FLAG_BIT = 0;                     // Data bit that carries a flag value.
    typedef enum logic [4:0] {
        DPC_IDLE  = 5'h01,
        DPC_SETUP = 5'h02,
        DPC_WRITE = 5'h04,
        DPC_READ  = 5'h08,
        DPC_DONE  = 5'h10
    } dpc_state_t;
endpackage

// *** dpc_mem_model.sv ***
/*
 * Behavioural model of the memory port that the controller drives, taken as the right port.
 * Assumes the bench resolves the data wire and plays the left port through its mailbox strobes.
 */
`timescale 1ns/1ps
module dpc_mem_model #(
    parameter int ACC_NS = 0                                // Read access delay; nonzero answers slowly.
) (
    input  wire logic [dpc_pkg::ADDR_W-1:0] mem_addr,
    input  wire logic                       port_select_n,
    input  wire logic                       write_strobe_n,
    input  wire logic                       output_enable_n,
    input  wire logic                       upper_byte_select_n,
    input  wire logic                       lower_byte_select_n,
    input  wire logic                       flag_access_select_n,
    input  wire logic [dpc_pkg::DATA_W-1:0] data_in,        // Resolved data wire.
    input  wire logic                       contention_n,   // Low level blocks array writes.
    input  wire logic                       left_post_n,    // Left port writes the right mailbox word.
    input  wire logic                       left_fetch_n,   // Left port reads its own mailbox word.
    output logic      [dpc_pkg::DATA_W-1:0] mem_q,          // Read data.
    output logic      [1:0]                 mem_en,         // Lane drive enables, bit 1 upper.
    output logic                            mailbox_n,
    output logic                            left_mailbox_n  // Mailbox level of the left port.
);
    logic [15:0] mem [0:4095];      // Array contents.
    logic [7:0]  flag_reg = 8'hFF;  // Free flags read as one.
    logic        mb_reg = 1'b0;     // Right mailbox; undefined at power-up, shown as pending.
    logic        left_mb_reg = 1'b0; // Left mailbox, with the same start.
    logic        wr_on;             // Overlap of strobe, select and lane.
    logic        rd_arr;            // Array read enabled.
    logic        rd_flag;           // Flag read enabled.
    // A write lasts only while all its enables overlap.
    assign wr_on = ~write_strobe_n & (~flag_access_select_n
        | (~port_select_n & ~(upper_byte_select_n & lower_byte_select_n)));
    assign rd_arr = ~port_select_n & write_strobe_n & ~output_enable_n & flag_access_select_n;
    assign rd_flag = ~flag_access_select_n & write_strobe_n & ~output_enable_n;
    // Reads need the strobe high, so a write never turns the drivers on.
    assign #(ACC_NS) mem_en = rd_flag ? 2'b11 : {2{rd_arr}} & ~{upper_byte_select_n, lower_byte_select_n};
    assign #(ACC_NS) mem_q = rd_flag ? {16{flag_reg[mem_addr[2:0]]}} : mem[mem_addr];
    assign mailbox_n = mb_reg;
    assign left_mailbox_n = left_mb_reg;
    // Commit as the first enable rises, while address and data are still held.
    always @(negedge wr_on) begin
        if (!flag_access_select_n) begin
            // Only this port's flag writes land here; the flag takes data bit zero as written.
            flag_reg[mem_addr[2:0]] <= data_in[0];
        end else if (contention_n) begin // A low contention level blocks the write.
            if (!upper_byte_select_n) mem[mem_addr][15:8] <= data_in[15:8];
            if (!lower_byte_select_n) mem[mem_addr][7:0] <= data_in[7:0];
        end
    end
    // Right mailbox: the left port's post sets it, reading the own mailbox word clears it.
    always @(posedge rd_arr or negedge left_post_n) begin
        if (!left_post_n) mb_reg <= 1'b0;
        else if (mem_addr == dpc_pkg::MAILBOX_RIGHT_ADDR) mb_reg <= 1'b1;
    end
    // Left mailbox: an unblocked right write to its word sets it, the left port's read clears it.
    always @(negedge wr_on or negedge left_fetch_n) begin
        if (!left_fetch_n) left_mb_reg <= 1'b1;
        else if (flag_access_select_n && contention_n && (mem_addr == dpc_pkg::MAILBOX_LEFT_ADDR)) begin
            left_mb_reg <= 1'b0;
        end
    end
endmodule

// *** dual_port_ram_port_control_bench.sv ***
/*
 * Self-checking bench for the port controller against the memory model.
 * Assumes a 25 MHz clock; expectations are queued by the driver, checked by a monitor.
 */
`timescale 1ns/1ps
module dual_port_ram_port_control_bench;
    typedef struct {logic rd; logic [15:0] v; logic [15:0] m;} dpc_note_t;
    logic ref_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_flag = 1'b0;
    logic [11:0] req_addr = 12'h000;
    logic [15:0] req_wdata = 16'h0000, junk = 16'h0000, sh [16], data_out, data_in, mem_q;
    logic [11:0] ad [16], mem_addr, prev_addr;
    logic [1:0]  req_lanes = 2'b11, mem_en;
    logic req_ready, rsp_valid, rsp_blocked, port_select_n, write_strobe_n, output_enable_n, data_oe;
    logic upper_byte_select_n, lower_byte_select_n, flag_access_select_n, mailbox_n, mailbox_pending;
    logic [15:0] rsp_rdata, d;
    logic contention_n = 1'b1;
    logic left_post_n = 1'b1, left_fetch_n = 1'b1, left_mailbox_n;
    logic [1:0] ln;
    int n_fail = 0, checks_done = 0;
    dpc_note_t notes [$];
    dpc_note_t nt;
    // Released lanes show a pattern that changes every cycle, never the last value.
    assign data_in = {mem_en[1] ? mem_q[15:8] : (data_oe ? data_out[15:8] : junk[15:8]),
                      mem_en[0] ? mem_q[7:0] : (data_oe ? data_out[7:0] : junk[7:0])};
    dpc_port_ctrl u_dut (.ref_clk, .rst, .req_valid, .req_write, .req_flag, .req_addr, .req_wdata,
        .req_lanes, .req_ready, .rsp_valid, .rsp_rdata, .rsp_blocked, .mem_addr, .port_select_n,
        .write_strobe_n, .output_enable_n, .upper_byte_select_n, .lower_byte_select_n,
        .flag_access_select_n, .data_in, .data_out, .data_oe, .contention_n, .mailbox_n, .mailbox_pending);
    dpc_mem_model #(.ACC_NS(30)) u_mem (.mem_addr, .port_select_n, .write_strobe_n, .output_enable_n,
        .upper_byte_select_n, .lower_byte_select_n, .flag_access_select_n, .data_in, .contention_n,
        .mem_q, .mem_en, .mailbox_n, .left_post_n, .left_fetch_n, .left_mailbox_n);
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // One request: wait for idle, pulse valid for one cycle, then wait for the completion pulse.
    task automatic op(input logic w, f, input logic [11:0] a, input logic [15:0] dt, ev,
                      input logic [1:0] l, input logic [15:0] m);
        int n;
        n = 0;
        do begin @(posedge ref_clk); #2; end while (req_ready !== 1'b1);
        notes.push_back('{~w, ev, m});
        {req_write, req_flag, req_addr, req_wdata, req_lanes, req_valid} = {w, f, a, dt, l, 1'b1};
        @(posedge ref_clk); #2;
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 30) begin @(posedge ref_clk); #2; n++; end
        if (n == 30) chk("completion", 16'h0001, 16'h0000);
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] dt, input logic [1:0] l, input logic b);
        op(1'b1, 1'b0, a, dt, {15'h0000, b}, l, 16'h0001);
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] l, input logic [15:0] ev);
        op(1'b0, 1'b0, a, 16'h0000, ev, l, {{8{l[1]}}, {8{l[0]}}});
    endtask
    // Monitor: pairs every completion with the oldest note and watches the wire every cycle.
    always @(posedge ref_clk) begin
        junk <= junk + 16'h3B5D;
        prev_addr <= mem_addr;
        // Pins are unknown until the first reset edge, so the wire is watched only out of reset.
        if (!rst) begin
            chk("drive_clash", 16'h0000, {15'h0000, data_oe & (|mem_en)});
            chk("addr_move", 16'h0000, {15'h0000, (mem_addr != prev_addr) & ~write_strobe_n
                & ~port_select_n & ~(upper_byte_select_n & lower_byte_select_n)});
            if (rsp_valid === 1'b1) begin
                if (notes.size() == 0) begin
                    chk("spare_response", 16'h0000, 16'h0001);
                end else begin
                    nt = notes.pop_front();
                    if (nt.rd) chk("rsp_rdata", nt.v & nt.m, rsp_rdata & nt.m);
                    else chk("rsp_blocked", nt.v, {15'h0000, rsp_blocked});
                end
            end
        end
    end
    initial begin
        #(40 * 6000);
        n_fail++;
        summarize();
    end
    initial begin
        void'($urandom(74458));
        repeat (10) @(posedge ref_clk);
        #2 rst = 1'b0;
        chk("idle_pins", 16'h003F, {9'h000, data_oe, port_select_n, write_strobe_n, output_enable_n,
            upper_byte_select_n, lower_byte_select_n, flag_access_select_n});
        // Both mailboxes come up undefined; each port clears its own before use.
        wr(dpc_pkg::MAILBOX_RIGHT_ADDR, 16'h0000, 2'b11, 1'b0);
        rd(dpc_pkg::MAILBOX_RIGHT_ADDR, 2'b11, 16'h0000);
        left_fetch_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        #2 left_fetch_n = 1'b1;
        chk("mailbox_init", 16'h0003, {14'h0000, left_mailbox_n, ~mailbox_pending});
        // Lanes merge into one word and reads drive only the selected lanes.
        wr(12'h123, 16'hA5C3, 2'b11, 1'b0);
        wr(12'h123, 16'h1E00, 2'b10, 1'b0);
        wr(12'h123, 16'hFF7E, 2'b01, 1'b0);
        for (int l = 1; l < 4; l++) rd(12'h123, l[1:0], 16'h1E7E);
        // Random words with random partial overwrites, read back through random lanes.
        for (int k = 0; k < 16; k++) begin
            ad[k] = {4'h4, k[3:0], 4'h0} | 12'($urandom_range(0, 15));
            sh[k] = 16'($urandom);
            wr(ad[k], sh[k], 2'b11, 1'b0);
            d = 16'($urandom);
            ln = 2'($urandom_range(1, 3));
            wr(ad[k], d, ln, 1'b0);
            sh[k] = (sh[k] & ~{{8{ln[1]}}, {8{ln[0]}}}) | (d & {{8{ln[1]}}, {8{ln[0]}}});
        end
        for (int k = 0; k < 16; k++) rd(ad[k], 2'($urandom_range(1, 3)), sh[k]);
        // Each flag: free, taken by bit 0 alone, seen through other high bits, released.
        for (int i = 0; i < 8; i++) begin
            op(1'b0, 1'b1, {9'($urandom), i[2:0]}, 16'h0000, 16'hFFFF, 2'b11, 16'hFFFF);
            op(1'b1, 1'b1, {9'($urandom), i[2:0]}, 16'hFFFE, 16'h0000, 2'b11, 16'h0001);
            op(1'b0, 1'b1, {9'($urandom), i[2:0]}, 16'h0000, 16'h0000, 2'b11, 16'hFFFF);
            op(1'b1, 1'b1, {9'($urandom), i[2:0]}, 16'h0001, 16'h0000, 2'b11, 16'h0001);
            op(1'b0, 1'b1, {9'($urandom), i[2:0]}, 16'h0000, 16'hFFFF, 2'b11, 16'hFFFF);
        end
        // A write under contention is reported and leaves the word alone.
        contention_n = 1'b0; // The bench plays the arbiter, which blocks this port.
        wr(12'h123, 16'h0000, 2'b11, 1'b1);
        contention_n = 1'b1;
        rd(12'h123, 2'b11, 16'h1E7E);
        // Mailbox raised by the left port, cleared by reading its word.
        wr(dpc_pkg::MAILBOX_RIGHT_ADDR, 16'h5A5A, 2'b11, 1'b0);
        left_post_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        #2 left_post_n = 1'b1;
        chk("mailbox_set", 16'h0001, {15'h0000, mailbox_pending});
        rd(dpc_pkg::MAILBOX_RIGHT_ADDR, 2'b11, 16'h5A5A);
        repeat (4) @(posedge ref_clk);
        #2 chk("mailbox_clear", 16'h0000, {15'h0000, mailbox_pending});
        // A write of the left mailbox word by this port raises the left mailbox.
        wr(dpc_pkg::MAILBOX_LEFT_ADDR, 16'hC33C, 2'b11, 1'b0);
        chk("left_mailbox", 16'h0000, {15'h0000, left_mailbox_n});
        repeat (4) @(posedge ref_clk);
        summarize();
    end
endmodule
